// ===== rtl/vic_pkg.sv
// vic_pkg: register map, reset values and field positions of the
// vectored interrupt controller register block.
// assumes a 32-bit classic wishbone slave port with byte addresses.
package vic_pkg;

	localparam int unsigned NSRC = 32;

	// byte addresses
	localparam logic [31:0] ADR_SVR_BASE = 32'hfffff080;
	localparam logic [31:0] ADR_IVR = 32'hfffff100;
	localparam logic [31:0] ADR_FVR = 32'hfffff104;
	localparam logic [31:0] ADR_ISR = 32'hfffff108;
	localparam logic [31:0] ADR_IPR = 32'hfffff10c;
	localparam logic [31:0] ADR_IMR = 32'hfffff110;
	localparam logic [31:0] ADR_CISR = 32'hfffff114;
	localparam logic [31:0] ADR_IECR = 32'hfffff120;
	localparam logic [31:0] ADR_IDCR = 32'hfffff124;
	localparam logic [31:0] ADR_ICCR = 32'hfffff128;
	localparam logic [31:0] ADR_ISCR = 32'hfffff12c;
	localparam logic [31:0] ADR_EOI = 32'hfffff130;
	localparam logic [31:0] ADR_SPU = 32'hfffff134;
	localparam logic [31:0] ADR_DCR = 32'hfffff138;
	localparam logic [31:0] ADR_FFER = 32'hfffff140;
	localparam logic [31:0] ADR_WPMR = 32'hfffff1e4;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RST_DCR = 2'h0;
	localparam logic [4:0] RST_CUR = 5'h00;

	// field positions
	localparam int DBG_PROTECT_BIT = 0;
	localparam int DBG_LINE_MASK_BIT = 1;
	localparam int CISR_FAST_BIT = 0;
	localparam int CISR_NORM_BIT = 1;
	localparam int WPMR_EN_BIT = 0;

	// source bit of the fast source
	localparam logic [31:0] SRC_FAST_MASK = 32'h0000_0001;

endpackage

// ===== rtl/vic_regs.sv
// vic_regs: register block of a vectored interrupt controller with
// source vectors, pending/mask state, fast forcing and core lines.
// assumes classic wishbone master, sources synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: fast vector read returns handler address stored for source 0.
// RULE2: with no fast interrupt active, fast vector read returns spurious vector.
// RULE3: current-source status returns serviced source number, upper bits zero.
// RULE4: pending view: bit 0 fast, bit 1 system, 2..31 peripherals.
// RULE5: mask view shows 1 for each enabled source, same layout.
// RULE6: core status bit 0 fast line active, bit 1 normal line active.
// RULE7: enable command: 1 enables source, 0 leaves it unchanged.
// RULE8: disable command: 1 disables source and clears mask bit, 0 nothing.
// RULE9: clear command: 1 clears latched interrupt, 0 leaves it.
// RULE10: set command: 1 latches interrupt as software trigger, 0 nothing.
// RULE11: any write to end-of-interrupt ends the current treatment.
// RULE12: spurious vector returned by normal and fast vector reads when spurious.
// RULE13: spurious vector and debug control writes ignored while write protect set.
// RULE14: debug bit 0 selects protection mode, resets to 0.
// RULE15: debug bit 1 high holds both outgoing lines inactive.
// RULE16: fast forcing enable is write-only, bits 1..31, bit 0 unused.
// RULE17: fast forcing enable: 1 routes source to fast path, 0 no change.
// RULE18: normal vector read returns current source vector, else spurious vector.
// RULE19: normal line on enabled pending non-fast source; fast line on fast ones.
module vic_regs
	import vic_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic [31:0] src_i,
	output logic fast_request_line_n_o,
	output logic normal_request_line_n_o
);

	function automatic logic [4:0] lowest_set(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		return (old & ~lane_mask(sel)) | (dat & lane_mask(sel));
	endfunction

	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic [31:0] mask_r, mask_nxt;
	logic [31:0] pend_r, pend_nxt;
	logic [31:0] ff_r, ff_nxt;
	logic [31:0] src_q_r, src_q_nxt;
	logic [31:0] spu_r, spu_nxt;
	logic [1:0] dcr_r, dcr_nxt;
	logic wp_on_r, wp_on_nxt;
	logic [4:0] cur_r, cur_nxt;
	logic cur_v_r, cur_v_nxt;
	logic fast_n_r, fast_n_nxt;
	logic norm_n_r, norm_n_nxt;
	logic [31:0] svr_r [NSRC];
	logic [31:0] svr_nxt [NSRC];

	logic acc, wr, rd, svr_hit, take;
	logic [31:0] cmd, norm_cand, fast_vec, ivr_vec, fast_cand;
	logic fast_act;

	// bus decode
	assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr = acc & wb_we_i;
	assign rd = acc & ~wb_we_i;
	assign cmd = wb_dat_i & lane_mask(wb_sel_i);
	assign svr_hit = (wb_adr_i[31:7] == ADR_SVR_BASE[31:7]);

	// source selection
	assign norm_cand = pend_r & mask_r & ~ff_r & ~SRC_FAST_MASK; // [RULE19]
	assign fast_cand = pend_r & mask_r & (ff_r | SRC_FAST_MASK); // [RULE17] [RULE19]
	assign fast_act = |fast_cand;
	assign fast_vec = fast_act ? svr_r[0] : spu_r; // [RULE1] [RULE2] [RULE12]
	assign ivr_vec = cur_v_r ? svr_r[cur_r] :
		((|norm_cand) ? svr_r[lowest_set(norm_cand)] : spu_r); // [RULE18] [RULE12]

	// acknowledge: read in normal mode, write in protection mode
	assign take = (wb_adr_i == ADR_IVR) &
		((rd & ~dcr_r[DBG_PROTECT_BIT]) | (wr & dcr_r[DBG_PROTECT_BIT])); // [RULE14]

	// bus answer
	always_comb begin
		ack_nxt = acc;
		dat_nxt = RST_WORD;
		if (rd) begin
			if (svr_hit) begin
				dat_nxt = svr_r[wb_adr_i[6:2]];
			end else begin
				case (wb_adr_i)
					ADR_IVR: dat_nxt = ivr_vec; // [RULE18]
					ADR_FVR: dat_nxt = fast_vec; // [RULE1] [RULE2]
					ADR_ISR: dat_nxt = {27'h0, cur_r}; // [RULE3]
					ADR_IPR: dat_nxt = pend_r; // [RULE4]
					ADR_IMR: dat_nxt = mask_r; // [RULE5]
					ADR_CISR: begin
						dat_nxt[CISR_FAST_BIT] = ~fast_n_r; // [RULE6]
						dat_nxt[CISR_NORM_BIT] = ~norm_n_r; // [RULE6]
					end
					ADR_SPU: dat_nxt = spu_r;
					ADR_DCR: dat_nxt = {30'h0, dcr_r};
					ADR_WPMR: dat_nxt = {31'h0, wp_on_r};
					default: dat_nxt = RST_WORD;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= RST_WORD;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	// interrupt state
	always_comb begin
		logic [31:0] ack_clr;
		logic [31:0] clr;
		logic [31:0] set;
		ack_clr = RST_WORD;
		clr = RST_WORD;
		set = RST_WORD;
		mask_nxt = mask_r;
		ff_nxt = ff_r;
		cur_nxt = cur_r;
		cur_v_nxt = cur_v_r;
		src_q_nxt = src_i;
		if (wr && wb_adr_i == ADR_IECR) begin
			mask_nxt = mask_r | cmd; // [RULE7]
		end
		if (wr && wb_adr_i == ADR_IDCR) begin
			mask_nxt = mask_r & ~cmd; // [RULE8]
		end
		if (wr && wb_adr_i == ADR_ICCR) begin
			clr = cmd; // [RULE9]
		end
		if (wr && wb_adr_i == ADR_ISCR) begin
			set = cmd; // [RULE10]
		end
		if (wr && wb_adr_i == ADR_FFER) begin
			ff_nxt = ff_r | (cmd & ~SRC_FAST_MASK); // [RULE16] [RULE17]
		end
		if (take && !cur_v_r && (|norm_cand)) begin // [RULE11]
			cur_nxt = lowest_set(norm_cand);
			cur_v_nxt = 1'b1;
			ack_clr = 32'h1 << lowest_set(norm_cand);
		end
		if (wr && wb_adr_i == ADR_EOI) begin
			cur_v_nxt = 1'b0; // [RULE11]
		end
		// new edges and set command win over clear
		pend_nxt = (pend_r & ~clr & ~ack_clr) | set | (src_i & ~src_q_r); // [RULE9] [RULE10]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_r <= RST_WORD;
			pend_r <= RST_WORD;
			ff_r <= RST_WORD;
			src_q_r <= RST_WORD;
			cur_r <= RST_CUR;
			cur_v_r <= 1'b0;
		end else begin
			mask_r <= mask_nxt;
			pend_r <= pend_nxt;
			ff_r <= ff_nxt;
			src_q_r <= src_q_nxt;
			cur_r <= cur_nxt;
			cur_v_r <= cur_v_nxt;
		end
	end

	// configuration registers
	always_comb begin
		spu_nxt = spu_r;
		dcr_nxt = dcr_r;
		wp_on_nxt = wp_on_r;
		for (int i = 0; i < NSRC; i++) begin
			svr_nxt[i] = svr_r[i];
		end
		if (wr && !wp_on_r) begin // [RULE13]
			if (svr_hit) begin
				svr_nxt[wb_adr_i[6:2]] = merge(svr_r[wb_adr_i[6:2]], wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == ADR_SPU) begin
				spu_nxt = merge(spu_r, wb_dat_i, wb_sel_i); // [RULE12]
			end
			if (wb_adr_i == ADR_DCR && wb_sel_i[0]) begin
				dcr_nxt = wb_dat_i[1:0]; // [RULE14] [RULE15]
			end
		end
		if (wr && wb_adr_i == ADR_WPMR && wb_sel_i[0]) begin
			wp_on_nxt = wb_dat_i[WPMR_EN_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			spu_r <= RST_WORD;
			dcr_r <= RST_DCR; // [RULE14]
			wp_on_r <= 1'b0;
			for (int i = 0; i < NSRC; i++) begin
				svr_r[i] <= RST_WORD;
			end
		end else begin
			spu_r <= spu_nxt;
			dcr_r <= dcr_nxt;
			wp_on_r <= wp_on_nxt;
			for (int i = 0; i < NSRC; i++) begin
				svr_r[i] <= svr_nxt[i];
			end
		end
	end

	// core lines
	always_comb begin
		fast_n_nxt = ~(fast_act & ~dcr_r[DBG_LINE_MASK_BIT]); // [RULE15] [RULE19]
		norm_n_nxt = ~((|norm_cand) & ~dcr_r[DBG_LINE_MASK_BIT]); // [RULE15] [RULE19]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_n_r <= 1'b1;
			norm_n_r <= 1'b1;
		end else begin
			fast_n_r <= fast_n_nxt;
			norm_n_r <= norm_n_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign fast_request_line_n_o = fast_n_r;
	assign normal_request_line_n_o = norm_n_r;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_fvr_read;
		rd && wb_adr_i == ADR_FVR && fast_act |=> wb_dat_o == $past(svr_r[0]);
	endproperty
	a_fvr_read: assert property (p_fvr_read) else $error("fast vector read wrong"); // [RULE1]

	property p_fvr_spur;
		rd && wb_adr_i == ADR_FVR && !fast_act |=> wb_dat_o == $past(spu_r);
	endproperty
	a_fvr_spur: assert property (p_fvr_spur) else $error("spurious fast vector wrong"); // [RULE2]

	property p_isr_read;
		rd && wb_adr_i == ADR_ISR |=> wb_dat_o == {27'h0, $past(cur_r)} && wb_ack_o;
	endproperty
	a_isr_read: assert property (p_isr_read) else $error("current source read wrong"); // [RULE3]

	property p_ipr_read;
		rd && wb_adr_i == ADR_IPR |=> wb_dat_o == $past(pend_r);
	endproperty
	a_ipr_read: assert property (p_ipr_read) else $error("pending read wrong"); // [RULE4]

	property p_imr_read;
		rd && wb_adr_i == ADR_IMR |=> wb_dat_o == $past(mask_r);
	endproperty
	a_imr_read: assert property (p_imr_read) else $error("mask read wrong"); // [RULE5]

	property p_cisr_read;
		rd && wb_adr_i == ADR_CISR |=> wb_dat_o[1:0] == ~$past({norm_n_r, fast_n_r});
	endproperty
	a_cisr_read: assert property (p_cisr_read) else $error("line status wrong"); // [RULE6]

	property p_enable;
		wr && wb_adr_i == ADR_IECR && wb_sel_i == 4'hf
			|=> (mask_r & $past(wb_dat_i)) == $past(wb_dat_i)
			&& (mask_r & ~$past(wb_dat_i)) == ($past(mask_r) & ~$past(wb_dat_i));
	endproperty
	a_enable: assert property (p_enable) else $error("enable command wrong"); // [RULE7]

	property p_disable;
		wr && wb_adr_i == ADR_IDCR && wb_sel_i == 4'hf |=> (mask_r & $past(wb_dat_i)) == 32'h0;
	endproperty
	a_disable: assert property (p_disable) else $error("disable command wrong"); // [RULE8]

	property p_set;
		wr && wb_adr_i == ADR_ISCR && wb_sel_i == 4'hf
			|=> (pend_r & $past(wb_dat_i)) == $past(wb_dat_i);
	endproperty
	a_set: assert property (p_set) else $error("set command wrong"); // [RULE10]

	property p_eoi;
		wr && wb_adr_i == ADR_EOI |=> !cur_v_r;
	endproperty
	a_eoi: assert property (p_eoi) else $error("end of interrupt ignored"); // [RULE11]

	property p_protect;
		wr && wp_on_r && (wb_adr_i == ADR_SPU || wb_adr_i == ADR_DCR)
			|=> $stable(spu_r) && $stable(dcr_r);
	endproperty
	a_protect: assert property (p_protect) else $error("protected write took effect"); // [RULE13]

	property p_line_mask;
		dcr_r[DBG_LINE_MASK_BIT] |=> fast_request_line_n_o && normal_request_line_n_o;
	endproperty
	a_line_mask: assert property (p_line_mask) else $error("line active while masked"); // [RULE15]

	property p_norm_line;
		##1 !normal_request_line_n_o
			== $past((|(pend_r & mask_r & ~ff_r & ~SRC_FAST_MASK)) && !dcr_r[DBG_LINE_MASK_BIT]);
	endproperty
	a_norm_line: assert property (p_norm_line) else $error("normal line wrong"); // [RULE19]

	property p_fast_line;
		##1 !fast_request_line_n_o
			== $past((|(pend_r & mask_r & (ff_r | SRC_FAST_MASK))) && !dcr_r[DBG_LINE_MASK_BIT]);
	endproperty
	a_fast_line: assert property (p_fast_line) else $error("fast line wrong"); // [RULE19]

	property p_clear;
		wr && wb_adr_i == ADR_ICCR && wb_sel_i == 4'hf
			|=> (pend_r & $past(wb_dat_i) & ~$past(src_i & ~src_q_r)) == 32'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear command wrong"); // [RULE9]

	property p_force;
		wr && wb_adr_i == ADR_FFER && wb_sel_i == 4'hf
			|=> ff_r == ($past(ff_r) | ($past(wb_dat_i) & ~SRC_FAST_MASK));
	endproperty
	a_force: assert property (p_force) else $error("fast forcing write wrong"); // [RULE16] [RULE17]

	property p_ack_take;
		rd && wb_adr_i == ADR_IVR && !dcr_r[DBG_PROTECT_BIT] && !cur_v_r && (|norm_cand)
			|=> cur_v_r && wb_dat_o == svr_r[cur_r];
	endproperty
	a_ack_take: assert property (p_ack_take) else $error("normal vector read wrong"); // [RULE18]

	property p_spur_norm;
		rd && wb_adr_i == ADR_IVR && !cur_v_r && !(|norm_cand) |=> wb_dat_o == $past(spu_r);
	endproperty
	a_spur_norm: assert property (p_spur_norm) else $error("spurious normal vector wrong"); // [RULE12]

	property p_guard_read;
		rd && wb_adr_i == ADR_IVR && dcr_r[DBG_PROTECT_BIT] |=> $stable(cur_v_r) && $stable(cur_r);
	endproperty
	a_guard_read: assert property (p_guard_read) else $error("vector read acknowledged"); // [RULE14]

	property p_guard_write;
		wr && wb_adr_i == ADR_IVR && dcr_r[DBG_PROTECT_BIT] && !cur_v_r && (|norm_cand) |=> cur_v_r;
	endproperty
	a_guard_write: assert property (p_guard_write) else $error("vector write ignored"); // [RULE14]

	property p_cur_hold;
		cur_v_r && !(wr && wb_adr_i == ADR_EOI) |=> cur_v_r && $stable(cur_r);
	endproperty
	a_cur_hold: assert property (p_cur_hold) else $error("current source lost"); // [RULE11]

endmodule // vic_regs

`default_nettype wire

// ===== verification/vic_core_model.sv
// vic_core_model: processor core side of the two interrupt request lines.
// assumes active-low lines driven by the register block.
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
	input wire logic fast_request_line_n_i,
	input wire logic normal_request_line_n_i,
	output logic fast_active_o,
	output logic normal_active_o
);
	// core sees a request while a line is low
	assign fast_active_o = ~fast_request_line_n_i;
	assign normal_active_o = ~normal_request_line_n_i;
endmodule // vic_core_model
`default_nettype wire

// ===== verification/test_vic_regs.sv
// test_vic_regs: register-level tests of vic_regs over classic wishbone.
// assumes vic_pkg constants and vic_core_model on the request lines.
`timescale 1ns/1ps
`default_nettype none
module test_vic_regs
	import vic_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] src = 32'h0;
	logic ack;
	logic [31:0] rdat;
	logic fast_n;
	logic norm_n;
	logic fast_act;
	logic norm_act;
	int n_errors = 0;
	int tests_run = 0;
	localparam logic [31:0] SPV = 32'hcafe0010;
	always #20 clk_i = ~clk_i;
	vic_regs u_vic_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack),
		.wb_dat_o(rdat), .src_i(src), .fast_request_line_n_o(fast_n),
		.normal_request_line_n_o(norm_n));
	vic_core_model u_vic_core_model (.fast_request_line_n_i(fast_n),
		.normal_request_line_n_i(norm_n), .fast_active_o(fast_act),
		.normal_active_o(norm_act));
	task automatic finish_test();
		$display("counts: %0d checks, %0d mismatches", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		do @(posedge clk_i); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask
	task automatic tend(input string name);
		$display("test %0s done", name);
	endtask
	initial begin
		#(40 * 3000);
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(ADR_FVR, 32'h0);
		rc(ADR_ISR, 32'h0);
		rc(ADR_IPR, 32'h0);
		rc(ADR_IMR, 32'h0);
		rc(ADR_CISR, 32'h0);
		rc(ADR_DCR, 32'h0);
		rc(ADR_IECR, 32'h0);
		rc(32'hfffff118, 32'h0);
		tend("reset");
		wr(ADR_SPU, SPV);
		rc(ADR_FVR, SPV);
		rc(ADR_IVR, SPV);
		wr(ADR_SVR_BASE, 32'h0000_1000);
		wr(ADR_SVR_BASE + 32'h14, 32'h0000_5050);
		wr(ADR_IECR, 32'h21);
		rc(ADR_IMR, 32'h21);
		wr(ADR_IDCR, 32'h1);
		rc(ADR_IMR, 32'h20);
		tend("mask");
		@(posedge clk_i);
		src <= 32'h20;
		repeat (2) @(posedge clk_i);
		rc(ADR_IPR, 32'h20);
		rc(ADR_CISR, 32'h2);
		chk({fast_act, norm_act}, 2'h1);
		rc(ADR_IVR, 32'h5050);
		rc(ADR_ISR, 32'h5);
		rc(ADR_IPR, 32'h0);
		wr(ADR_ISCR, 32'h20);
		rc(ADR_IVR, 32'h5050);
		rc(ADR_IPR, 32'h20);
		wr(ADR_EOI, 32'hdeadbeef);
		rc(ADR_IVR, 32'h5050);
		rc(ADR_IPR, 32'h0);
		wr(ADR_EOI, 32'h0);
		rc(ADR_IVR, SPV);
		rc(ADR_CISR, 32'h0);
		src <= 32'h0;
		tend("normal");
		wr(ADR_IECR, 32'h1);
		wr(ADR_ISCR, 32'h1);
		rc(ADR_IPR, 32'h1);
		rc(ADR_CISR, 32'h1);
		rc(ADR_FVR, 32'h1000);
		chk({fast_act, norm_act}, 2'h2);
		wr(ADR_ICCR, 32'h1);
		rc(ADR_IPR, 32'h0);
		rc(ADR_FVR, SPV);
		tend("fast");
		wr(ADR_FFER, 32'h81);
		rc(ADR_FFER, 32'h0);
		wr(ADR_IECR, 32'h80);
		wr(ADR_ISCR, 32'h80);
		rc(ADR_CISR, 32'h1);
		rc(ADR_FVR, 32'h1000);
		wr(ADR_ICCR, 32'h80);
		rc(ADR_CISR, 32'h0);
		tend("forcing");
		wr(ADR_DCR, 32'h3);
		rc(ADR_DCR, 32'h3);
		wr(ADR_ISCR, 32'h20);
		rc(ADR_CISR, 32'h0);
		chk({fast_act, norm_act}, 2'h0);
		wr(ADR_DCR, 32'h1);
		rc(ADR_CISR, 32'h2);
		rc(ADR_IVR, 32'h5050);
		rc(ADR_IPR, 32'h20);
		wr(ADR_IVR, 32'h0);
		rc(ADR_IPR, 32'h0);
		wr(ADR_ICCR, 32'h20);
		rc(ADR_CISR, 32'h0);
		tend("debug");
		wr(ADR_WPMR, 32'h1);
		wr(ADR_SPU, 32'h1);
		wr(ADR_DCR, 32'h0);
		rc(ADR_SPU, SPV);
		rc(ADR_DCR, 32'h1);
		wr(ADR_WPMR, 32'h0);
		wr(ADR_DCR, 32'h0);
		rc(ADR_DCR, 32'h0);
		tend("protect");
		finish_test();
	end
endmodule // test_vic_regs
`default_nettype wire
